// *** design/tsr_defs.svh ***
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
// register byte offsets
`define TSR_OFF_DIR      12'h000
`define TSR_OFF_DOUT     12'h004
`define TSR_OFF_DIN      12'h008
`define TSR_OFF_PIN_OE   12'h00C
`define TSR_OFF_TB       12'h010
`define TSR_OFF_TRIG_OE  12'h014
`define TSR_OFF_TRIG_SEL 12'h018
`define TSR_OFF_STATUS   12'h01C
`define TSR_OFF_SRC_BASE 12'h040
// field positions
`define TSR_TB_SEL_BUS   0
`define TSR_TB_DRIVE     1
`define TSR_ST_UPDN0     0
`define TSR_ST_UPDN1     1
`define TSR_ST_BUSY      2
// reset values
`define TSR_RST_DIR      8'h00
`define TSR_RST_DOUT     8'h00
`define TSR_RST_PIN_OE   10'h000
`define TSR_RST_TB       2'h0
`define TSR_RST_TRIG_OE  7'h00
`define TSR_RST_TRIG_SEL 21'h000000
`define TSR_RST_SRC      5'h11
// source select codes
`define TSR_SRC_PIN_BASE 5'h07
`define TSR_SRC_GEN      5'h11
`define TSR_SRC_CTR0     5'h12
`endif

// *** design/tsr_pkg.sv ***
package tsr_pkg;
  // internal timing signals; index n also names function pin n
  typedef enum logic [3:0] {
    TS_START_TRIG                  = 4'h0,
    TS_REF_TRIG                    = 4'h1,
    TS_FUNCTION_PIN_TWO_CONVERSION = 4'h2,
    TS_CTR1_SOURCE                 = 4'h3,
    TS_CTR1_GATE                   = 4'h4,
    TS_FUNCTION_PIN_FIVE_UPDATE    = 4'h5,
    TS_WAVE_TRIG                   = 4'h6,
    TS_SCAN_START                  = 4'h7,
    TS_CTR0_SOURCE                 = 4'h8,
    TS_CTR0_GATE                   = 4'h9,
    TS_AI_STOP                     = 4'hA,
    TS_AO_START                    = 4'hB,
    TS_AUX_GATE                    = 4'hC
  } tsr_tsig_t;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tsr_apb_req_t;

  // trigger bus settings handed to the link domain
  typedef struct packed {
    logic [6:0]  oe;
    logic [20:0] sel;
  } tsr_link_cfg_t;
endpackage

// *** design/tsr_routing.sv ***
`include "tsr_defs.svh"
module tsr_routing (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  input  wire tsr_pkg::tsr_apb_req_t apb_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic                 link_clk_i,
  input  wire logic [7:0]           general_digital_line_i,
  output logic [7:0]                general_digital_line_o,
  output logic [7:0]                general_digital_line_oe_o,
  input  wire logic [9:0]           programmable_function_pin_i,
  output logic [9:0]                programmable_function_pin_o,
  output logic [9:0]                programmable_function_pin_oe_o,
  input  wire logic [6:0]           trig_i,
  output logic [6:0]                trig_o,
  output logic [6:0]                trig_oe_o,
  input  wire logic                 int_tb_i,
  input  wire logic                 bus_tb_i,
  output logic                      bus_tb_o,
  output logic                      bus_tb_oe_o,
  output logic                      primary_tb_o,
  input  wire logic [12:0]          tsig_int_i,
  input  wire logic                 sample_interval_terminal_count_i,
  input  wire logic                 counter_zero_output_i,
  output logic [12:0]               tsig_o,
  output logic                      ctr0_updn_o,
  output logic                      ctr1_updn_o
);
  import tsr_pkg::*;

  ////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]    dir_r;          // 1 = line drives
  logic [7:0]    dout_r;         // output levels
  logic [9:0]    pin_oe_r;       // function pin drivers
  logic [1:0]    tb_r;           // timebase control
  logic [6:0]    trig_oe_r;      // trigger line drivers
  logic [20:0]   trig_sel_r;     // 3 bits per trigger line
  logic [4:0]    src_sel_r [13]; // source code per timing signal
  logic [12:0]   tsig_r;         // routed timing signals
  logic [9:0]    pin_out_r;      // function pin levels
  logic [7:0]    dio_s1_r;       // digital line synchroniser
  logic [7:0]    dio_s2_r;
  logic [9:0]    pin_s1_r;       // function pin synchroniser
  logic [9:0]    pin_s2_r;
  logic [6:0]    ctrig_s1_r;     // trigger values into core
  logic [6:0]    ctrig_s2_r;
  logic [12:0]   gen_src;        // internal generator per signal
  logic          rvalid_r;       // apb answer ready
  logic [31:0]   prdata_r;
  logic          pslverr_r;
  logic [31:0]   rd_nxt;
  logic          hit_nxt;
  logic          wr_en;
  logic [11:0]   addr;
  logic [3:0]    sidx;           // source register index
  // config handover to link domain
  tsr_link_cfg_t shadow_r;
  tsr_link_cfg_t live_cfg;
  logic          req_r;
  logic          cack_s1_r;
  logic          cack_s2_r;
  logic          busy;
  // link domain
  logic          lrst_s1_r;
  logic          lrst_n_r;
  logic          lce_s1_r;
  logic          lce_r;
  logic          lreq_s1_r;
  logic          lreq_s2_r;
  logic          lreq_s3_r;
  tsr_link_cfg_t link_cfg_r;
  logic [6:0]    ltrig_s1_r;
  logic [6:0]    ltrig_s2_r;
  logic [7:0]    ltsig_s1_r;
  logic [7:0]    ltsig_s2_r;
  logic [6:0]    trig_out_r;

  ////////////////////////////////////////////////////////////////
  // apb slave, answers in the first access cycle when ce_i is high
  assign addr     = apb_i.paddr;
  assign sidx     = addr[5:2];
  assign pready_o = ce_i & rvalid_r;
  assign wr_en    = apb_i.psel & apb_i.penable & apb_i.pwrite & pready_o;
  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r;

  // read decode; unmapped addresses read zero with an error
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    hit_nxt = 1'b1;
    if (addr == `TSR_OFF_DIR) begin
      rd_nxt[7:0] = dir_r;
    end else if (addr == `TSR_OFF_DOUT) begin
      rd_nxt[7:0] = dout_r;
    end else if (addr == `TSR_OFF_DIN) begin
      rd_nxt[7:0] = dio_s2_r;
    end else if (addr == `TSR_OFF_PIN_OE) begin
      rd_nxt[9:0] = pin_oe_r;
    end else if (addr == `TSR_OFF_TB) begin
      rd_nxt[1:0] = tb_r;
    end else if (addr == `TSR_OFF_TRIG_OE) begin
      rd_nxt[6:0] = trig_oe_r;
    end else if (addr == `TSR_OFF_TRIG_SEL) begin
      rd_nxt[20:0] = trig_sel_r;
    end else if (addr == `TSR_OFF_STATUS) begin
      rd_nxt[`TSR_ST_UPDN0] = dio_s2_r[6];
      rd_nxt[`TSR_ST_UPDN1] = dio_s2_r[7];
      rd_nxt[`TSR_ST_BUSY]  = busy;
    end else if ({addr[11:6], 6'h00} == `TSR_OFF_SRC_BASE && addr[1:0] == 2'h0
                 && sidx < 4'hD) begin
      rd_nxt[4:0] = src_sel_r[sidx];
    end else begin
      hit_nxt = 1'b0;
    end
  end

  // answer flags and read data, loaded while the request waits
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rvalid_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (ce_i) begin
      rvalid_r <= apb_i.psel & ~(apb_i.penable & rvalid_r);
      if (apb_i.psel) begin
        prdata_r  <= rd_nxt;
        pslverr_r <= ~hit_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // digital lines: direction and output level
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dir_r  <= `TSR_RST_DIR;
      dout_r <= `TSR_RST_DOUT;
    end else if (wr_en && addr == `TSR_OFF_DIR) begin
      dir_r <= apb_i.pwdata[7:0];
    end else if (wr_en && addr == `TSR_OFF_DOUT) begin
      dout_r <= apb_i.pwdata[7:0];
    end
  end
  assign general_digital_line_o    = dout_r;
  assign general_digital_line_oe_o = dir_r;

  // line sampling; pad level is read whatever the direction
  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      dio_s1_r <= general_digital_line_i;
      dio_s2_r <= dio_s1_r;
    end
  end
  // taps only listen, they never touch dir_r or dout_r
  assign ctr0_updn_o = dio_s2_r[6];
  assign ctr1_updn_o = dio_s2_r[7];

  ////////////////////////////////////////////////////////////////
  // pin enables, timebase and trigger settings
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pin_oe_r   <= `TSR_RST_PIN_OE;
      tb_r       <= `TSR_RST_TB;
      trig_oe_r  <= `TSR_RST_TRIG_OE;
      trig_sel_r <= `TSR_RST_TRIG_SEL;
    end else if (wr_en) begin
      if (addr == `TSR_OFF_PIN_OE) begin
        pin_oe_r <= apb_i.pwdata[9:0];
      end else if (addr == `TSR_OFF_TB) begin
        tb_r <= apb_i.pwdata[1:0];
      end else if (addr == `TSR_OFF_TRIG_OE) begin
        trig_oe_r <= apb_i.pwdata[6:0];
      end else if (addr == `TSR_OFF_TRIG_SEL) begin
        trig_sel_r <= apb_i.pwdata[20:0];
      end
    end
  end

  // timebase: a plain clock mux, so a switch may glitch; change it idle
  assign primary_tb_o = tb_r[`TSR_TB_SEL_BUS] ? bus_tb_i : int_tb_i;
  assign bus_tb_o     = int_tb_i;
  assign bus_tb_oe_o  = ~tb_r[`TSR_TB_SEL_BUS] & tb_r[`TSR_TB_DRIVE];

  ////////////////////////////////////////////////////////////////
  // external sources into the core domain
  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      pin_s1_r   <= programmable_function_pin_i;
      pin_s2_r   <= pin_s1_r;
      ctrig_s1_r <= ltrig_s2_r;
      ctrig_s2_r <= ctrig_s1_r;
    end
  end

  // timing signal multiplexers, one per signal
  for (genvar k = 0; k < 13; k++) begin : g_route
    logic       route_nxt;
    logic [4:0] pidx;
    // conversion strobe takes the sample interval terminal count
    if (k == int'(TS_FUNCTION_PIN_TWO_CONVERSION)) begin : g_conv
      assign gen_src[k] = sample_interval_terminal_count_i;
    end else begin : g_other
      assign gen_src[k] = tsig_int_i[k];
    end
    assign pidx = src_sel_r[k] - `TSR_SRC_PIN_BASE;

    // select register; any code may repeat across signals
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        src_sel_r[k] <= `TSR_RST_SRC;
      end else if (wr_en && addr == `TSR_OFF_SRC_BASE + 12'(4 * k)) begin
        src_sel_r[k] <= apb_i.pwdata[4:0];
      end
    end

    // codes 0-6 trigger lines, 7-16 pins, 17 generator, 18 counter 0
    always_comb begin
      route_nxt = 1'b0;
      if (src_sel_r[k] < `TSR_SRC_PIN_BASE) begin
        route_nxt = ctrig_s2_r[src_sel_r[k][2:0]];
      end else if (src_sel_r[k] < `TSR_SRC_GEN) begin
        route_nxt = pin_s2_r[pidx[3:0]];
      end else if (src_sel_r[k] == `TSR_SRC_GEN) begin
        route_nxt = gen_src[k];
      end else if (src_sel_r[k] == `TSR_SRC_CTR0) begin
        route_nxt = counter_zero_output_i;
      end
    end

    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        tsig_r[k] <= 1'b0;
      end else if (ce_i) begin
        tsig_r[k] <= route_nxt;
      end
    end
  end
  assign tsig_o = tsig_r;

  // function pin outputs; pin n carries timing signal n
  for (genvar p = 0; p < 10; p++) begin : g_pin
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        pin_out_r[p] <= (p == 2);
      end else if (ce_i) begin
        // the conversion pin idles high, falls per conversion
        pin_out_r[p] <= (p == 2) ? ~tsig_r[p] : tsig_r[p];
      end
    end
  end
  assign programmable_function_pin_o    = pin_out_r;
  assign programmable_function_pin_oe_o = pin_oe_r;

  ////////////////////////////////////////////////////////////////
  // settings handover: toggle handshake, shadow held until acked
  assign live_cfg.oe  = trig_oe_r;
  assign live_cfg.sel = trig_sel_r;
  assign busy         = req_r ^ cack_s2_r;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shadow_r  <= '0;
      req_r     <= 1'b0;
      cack_s1_r <= 1'b0;
      cack_s2_r <= 1'b0;
    end else if (ce_i) begin
      cack_s1_r <= lreq_s3_r;
      cack_s2_r <= cack_s1_r;
      if (!busy && live_cfg != shadow_r) begin
        shadow_r <= live_cfg;
        req_r    <= ~req_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // link domain: reset and enable brought over by two flops
  always_ff @(posedge link_clk_i) begin
    lrst_s1_r <= rst_n_i;
    lrst_n_r  <= lrst_s1_r;
    lce_s1_r  <= ce_i;
    lce_r     <= lce_s1_r;
  end

  // link side of the handshake and the line samplers
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n_r) begin
      lreq_s1_r  <= 1'b0;
      lreq_s2_r  <= 1'b0;
      lreq_s3_r  <= 1'b0;
      link_cfg_r <= '0;
    end else if (lce_r) begin
      lreq_s1_r <= req_r;
      lreq_s2_r <= lreq_s1_r;
      lreq_s3_r <= lreq_s2_r;
      if (lreq_s2_r != lreq_s3_r) begin
        link_cfg_r <= shadow_r;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lce_r) begin
      ltrig_s1_r <= trig_i;
      ltrig_s2_r <= ltrig_s1_r;
      ltsig_s1_r <= tsig_r[7:0];
      ltsig_s2_r <= ltsig_s1_r;
    end
  end

  // each trigger line drives one of the first eight signals
  for (genvar j = 0; j < 7; j++) begin : g_trig
    always_ff @(posedge link_clk_i) begin
      if (!lrst_n_r) begin
        trig_out_r[j] <= 1'b0;
      end else if (lce_r) begin
        trig_out_r[j] <= ltsig_s2_r[link_cfg_r.sel[3*j +: 3]];
      end
    end
  end
  assign trig_o    = trig_out_r;
  assign trig_oe_o = link_cfg_r.oe;

  ////////////////////////////////////////////////////////////////
  // checks
  dio_hiz_reset_a: assert property (@(posedge clock_i)
    $rose(rst_n_i) |-> general_digital_line_oe_o == 8'h00)
    else $error("digital lines driven after reset");

  dio_dir_write_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    wr_en && addr == `TSR_OFF_DIR |=> general_digital_line_oe_o == $past(apb_i.pwdata[7:0]))
    else $error("direction write not applied");

  updn_tap_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    ce_i ##1 ce_i ##1 1'b1 |-> ctr0_updn_o == $past(general_digital_line_i[6], 2)
                            && ctr1_updn_o == $past(general_digital_line_i[7], 2))
    else $error("counter direction tap wrong");

  tap_no_drive_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    !wr_en |=> $stable(general_digital_line_oe_o) && $stable(general_digital_line_o))
    else $error("digital line changed without a write");

  tb_default_a: assert property (@(posedge clock_i)
    $rose(rst_n_i) |-> !bus_tb_oe_o && primary_tb_o == int_tb_i)
    else $error("timebase not internal after reset");

  tb_drive_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    wr_en && addr == `TSR_OFF_TB |=> bus_tb_oe_o == ($past(apb_i.pwdata[1:0]) == 2'h2))
    else $error("bus timebase driver wrong");

  pin_oe_write_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    wr_en && addr == `TSR_OFF_PIN_OE |=> programmable_function_pin_oe_o
                                          == $past(apb_i.pwdata[9:0]))
    else $error("pin enable write not applied");

  conv_pin_low_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    ce_i |=> programmable_function_pin_o[2] == !$past(tsig_o[2]))
    else $error("conversion pin not inverted strobe");

  pin_route_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    (ce_i && src_sel_r[2] == `TSR_SRC_PIN_BASE)[*3] |=>
      tsig_o[2] == $past(programmable_function_pin_i[0], 3))
    else $error("pin zero not routed to conversion");

  ctr0_route_a: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    ce_i && src_sel_r[2] == `TSR_SRC_CTR0 |=> tsig_o[2] == $past(counter_zero_output_i))
    else $error("counter 0 output not routed");

  shared_pin_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    src_sel_r[0] == src_sel_r[5] && src_sel_r[0] < `TSR_SRC_GEN
    && src_sel_r[0] >= `TSR_SRC_PIN_BASE);
  bus_tb_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) bus_tb_oe_o);
  dio_out_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    general_digital_line_oe_o[6] && ctr0_updn_o);
  trig_drive_c: cover property (@(posedge link_clk_i) disable iff (!lrst_n_r)
    trig_oe_o != 7'h00);
endmodule

// *** dv/tsr_far_side.sv ***
// far side: external circuits, digital pads and another board on the bus
module tsr_far_side (
  input  wire logic [7:0] line_i,
  input  wire logic [7:0] line_oe_i,
  input  wire logic [7:0] line_ext_i,
  input  wire logic [9:0] pin_i,
  input  wire logic [9:0] pin_oe_i,
  input  wire logic [9:0] pin_ext_i,
  input  wire logic [6:0] trig_i,
  input  wire logic [6:0] trig_oe_i,
  input  wire logic [6:0] trig_ext_i,
  output logic      [7:0] line_o,
  output logic      [9:0] pin_o,
  output logic      [6:0] trig_o,
  output logic            int_tb_o,
  output logic            bus_tb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // a pad shows this board's driver when enabled, else the outside circuit
  assign line_o = (line_oe_i & line_i) | (~line_oe_i & line_ext_i);
  assign pin_o  = (pin_oe_i & pin_i) | (~pin_oe_i & pin_ext_i);
  // the other board drives a trigger line only while this one leaves it free
  assign trig_o = (trig_oe_i & trig_i) | (~trig_oe_i & trig_ext_i);
  ////////////////////////////////////////////////////////////////////////////
  // local 20 MHz timebase; offset keeps its edges off the core clock edges
  initial begin
    int_tb_o = 1'b0;
    #3;
    forever #25 int_tb_o = ~int_tb_o;
  end
  // timebase received from another board, at a rate of its own
  initial begin
    bus_tb_o = 1'b0;
    #7;
    forever #30 bus_tb_o = ~bus_tb_o;
  end
endmodule

// *** dv/timing_signal_routing_dio_tb.sv ***
`include "tsr_defs.svh"
`define CHK(nm, ex, gt) begin \
  n_tests++; \
  if ((gt) !== (ex)) begin \
    mismatches++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module timing_signal_routing_dio_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tsr_pkg::*;
  logic        clock_i, rst_n_i, ce_i, link_clk_i, int_tb_i, bus_tb_i, e;
  logic        pready_o, pslverr_o, bus_tb_o, bus_tb_oe_o, primary_tb_o;
  logic        sample_interval_terminal_count_i, counter_zero_output_i;
  logic        ctr0_updn_o, ctr1_updn_o;
  logic [31:0] prdata_o, q;
  logic [7:0]  general_digital_line_i, general_digital_line_o;
  logic [7:0]  general_digital_line_oe_o, ext_line, r, d, ev;
  logic [9:0]  programmable_function_pin_i, programmable_function_pin_o;
  logic [9:0]  programmable_function_pin_oe_o, ext_pin, m;
  logic [6:0]  trig_i, trig_o, trig_oe_o, ext_trig, o, et;
  logic [12:0] tsig_int_i, tsig_o, tv;
  logic [20:0] s;
  tsr_apb_req_t apb_r;     // bus request driven by the bench
  int          c, k, j, t, p;
  int          mismatches, n_tests;

  tsr_routing i_tsr_routing (.clock_i, .rst_n_i, .ce_i, .apb_i(apb_r), .prdata_o, .pready_o,
    .pslverr_o, .link_clk_i, .general_digital_line_i, .general_digital_line_o,
    .general_digital_line_oe_o, .programmable_function_pin_i, .programmable_function_pin_o,
    .programmable_function_pin_oe_o, .trig_i, .trig_o, .trig_oe_o, .int_tb_i, .bus_tb_i,
    .bus_tb_o, .bus_tb_oe_o, .primary_tb_o, .tsig_int_i, .sample_interval_terminal_count_i,
    .counter_zero_output_i, .tsig_o, .ctr0_updn_o, .ctr1_updn_o);

  tsr_far_side i_tsr_far_side (.line_i(general_digital_line_o),
    .line_oe_i(general_digital_line_oe_o), .line_ext_i(ext_line),
    .pin_i(programmable_function_pin_o), .pin_oe_i(programmable_function_pin_oe_o),
    .pin_ext_i(ext_pin), .trig_i(trig_o), .trig_oe_i(trig_oe_o), .trig_ext_i(ext_trig),
    .line_o(general_digital_line_i), .pin_o(programmable_function_pin_i), .trig_o(trig_i),
    .int_tb_o(int_tb_i), .bus_tb_o(bus_tb_i));

  ////////////////////////////////////////////////////////////////////////////
  // core clock 100 ns, link clock 15 ns with an unrelated phase
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer; pready and the answer are taken at the rising edge itself
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt,
                     output logic [31:0] rq, output logic er);
    int n;
    @(posedge clock_i);
    apb_r <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: dt};
    @(posedge clock_i);
    apb_r.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    // a slave that never answers counts against the run
    if (pready_o !== 1'b1) mismatches++;
    rq = prdata_o;
    er = pslverr_o;
    apb_r <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt, q, e);
  endtask

  // settle for n core edges, then look between edges
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  // reference routing: what a source code should deliver to a timing signal
  function automatic logic exp_src(input int cd, input int sg);
    if (cd < 7) return ext_trig[cd];
    if (cd < 17) return ext_pin[cd - 7];
    if (cd == 17) return (sg == 2) ? sample_interval_terminal_count_i : tsig_int_i[sg];
    if (cd == 18) return counter_zero_output_i;
    return 1'b0;
  endfunction

  // hang guard, far beyond the length of the sequence
  initial begin
    #1000000;
    mismatches++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ce_i = 1'b1;
    rst_n_i = 1'b0;
    apb_r = '0;
    ext_line = 8'h00;
    ext_pin = 10'h000;
    ext_trig = 7'h00;
    tsig_int_i = 13'h0000;
    sample_interval_terminal_count_i = 1'b0;
    counter_zero_output_i = 1'b0;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(51134));
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    `CHK("line_oe", 8'h00, general_digital_line_oe_o)
    `CHK("tb_oe", 1'b0, bus_tb_oe_o)
    `CHK("prim_tb", int_tb_i, primary_tb_o)
    `CHK("conv_idle", 1'b1, programmable_function_pin_o[2])
    apb(1'b0, `TSR_OFF_SRC_BASE + 12'h008, 32'h0, q, e);
    `CHK("src_rst", 32'h00000011, q)
    apb(1'b1, 12'h100, 32'hFFFFFFFF, q, e);
    `CHK("bad_wr", 1'b1, e)
    apb(1'b0, 12'h100, 32'h0, q, e);
    `CHK("bad_rd", 33'h100000000, {e, q})
    // digital lines: direction, levels and counter direction taps
    repeat (4) begin
      r = 8'($urandom);
      d = 8'($urandom);
      @(posedge clock_i);
      ext_line <= 8'($urandom);
      wr(`TSR_OFF_DIR, {24'h0, r});
      @(negedge clock_i);
      `CHK("line_oe", r, general_digital_line_oe_o)
      wr(`TSR_OFF_DOUT, {24'h0, d});
      settle(0);
      `CHK("line_out", d, general_digital_line_o)
      ev = (r & d) | (~r & ext_line);
      settle(3);
      `CHK("updn0", ev[6], ctr0_updn_o)
      `CHK("updn1", ev[7], ctr1_updn_o)
      apb(1'b0, `TSR_OFF_DIN, 32'h0, q, e);
      `CHK("din", {24'h0, ev}, q)
      apb(1'b0, `TSR_OFF_STATUS, 32'h0, q, e);
      `CHK("st_updn", ev[7:6], q[1:0])
      `CHK("line_oe", r, general_digital_line_oe_o)
    end
    // conversion strobe: source codes 0 to 20, the unused codes 19 and 20 included
    for (c = 0; c < 21; c++) begin
      @(posedge clock_i);
      ext_pin <= 10'($urandom);
      ext_trig <= 7'($urandom);
      tsig_int_i <= 13'($urandom);
      sample_interval_terminal_count_i <= 1'($urandom);
      counter_zero_output_i <= 1'($urandom);
      wr(`TSR_OFF_SRC_BASE + 12'h008, 32'(c));
      settle(8);
      `CHK("src2", exp_src(c, 2), tsig_o[2])
    end
    // every timing signal from its internal generator
    for (k = 0; k < 13; k++) wr(`TSR_OFF_SRC_BASE + 12'(4 * k), 32'h11);
    tv = tsig_int_i;
    tv[2] = sample_interval_terminal_count_i;
    settle(3);
    `CHK("tsig_int", tv, tsig_o)
    // function pin drivers; pin two goes out inverted
    m = 10'($urandom);
    wr(`TSR_OFF_PIN_OE, {22'h0, m});
    settle(3);
    `CHK("pin_oe", m, programmable_function_pin_oe_o)
    `CHK("pin_out", tv[9:0] ^ 10'h004, programmable_function_pin_o)
    // trigger lines driving chosen timing signals
    s = 21'($urandom);
    o = 7'($urandom);
    wr(`TSR_OFF_TRIG_SEL, {11'h0, s});
    wr(`TSR_OFF_TRIG_OE, {25'h0, o});
    settle(12);
    for (j = 0; j < 7; j++) et[j] = tv[s[3*j +: 3]];
    `CHK("trig_oe", o, trig_oe_o)
    `CHK("trig_out", et, trig_o)
    // two timing signals sharing one function pin
    p = $urandom % 10;
    wr(`TSR_OFF_PIN_OE, 32'h0);
    wr(`TSR_OFF_SRC_BASE, 32'(7 + p));
    wr(`TSR_OFF_SRC_BASE + 12'h024, 32'(7 + p));
    settle(4);
    `CHK("share0", ext_pin[p], tsig_o[0])
    `CHK("share9", ext_pin[p], tsig_o[9])
    // clock enable low: routed signals hold while the shared pin flips
    @(posedge clock_i);
    ce_i <= 1'b0;
    ext_pin <= ~ext_pin;
    tv = tsig_o;
    settle(4);
    `CHK("ce_hold", tv, tsig_o)
    @(posedge clock_i);
    ce_i <= 1'b1;
    settle(4);
    `CHK("share0", ext_pin[p], tsig_o[0])
    `CHK("share9", ext_pin[p], tsig_o[9])
    // timebase select and bus driver, all four settings
    for (t = 0; t < 4; t++) begin
      wr(`TSR_OFF_TB, 32'(t));
      repeat (4) begin
        @(negedge clock_i);
        `CHK("tb_oe", 1'(t == 2), bus_tb_oe_o)
        `CHK("tb_out", int_tb_i, bus_tb_o)
        `CHK("prim_tb", (t % 2) ? bus_tb_i : int_tb_i, primary_tb_o)
      end
    end
    test_done();
  end
endmodule
